// ### inc/boot_seq_defs.vh
`ifndef BOOT_SEQ_DEFS_VH
`define BOOT_SEQ_DEFS_VH
// Reference clock period and core clock period, ns
`define REF_PERIOD_NS      200
`define CORE_PERIOD_NS     50
`define CYC_PER_REF        (`REF_PERIOD_NS / `CORE_PERIOD_NS)
// Start-up phase lengths in reference periods
`define RESET_DELAY_REFS   144
`define SCAN_REFS          144
`define CONFIG_READS       36
`define REFRESH_COUNT      8
// Boot addresses
`define ROM_BOOT_ADDR      32'h07FFFFFE
`define FIRST_USER_DEFAULT 32'h80000070
// Control byte codes
`define CTRL_POKE          8'h00
`define CTRL_PEEK          8'h01
`endif

// ### src/pair_buffer.v
`timescale 1ns/1ps
module pair_buffer #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] slot0_reg;
  reg [WIDTH-1:0] slot1_reg;
  reg [1:0]       count_reg;
  wire            push;
  wire            pop;

  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = slot0_reg;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (rst) begin
      count_reg <= 2'h0;
      slot0_reg <= {WIDTH{1'b0}};
      slot1_reg <= {WIDTH{1'b0}};
    end else begin
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      if (pop) begin
        slot0_reg <= (push && count_reg == 2'h1) ? in_data : slot1_reg;
        if (push && count_reg == 2'h2)
          slot1_reg <= in_data;
      end else if (push) begin
        if (count_reg == 2'h0)
          slot0_reg <= in_data;
        else
          slot1_reg <= in_data;
      end
    end
  end
endmodule

// ### src/reset_link_boot_loader.v
`timescale 1ns/1ps
`include "boot_seq_defs.vh"
module reset_link_boot_loader #(
  parameter NLINK        = 4,
  parameter AW           = 32,
  parameter CFG_DELAY    = 16,
  parameter START_ADDR   = `FIRST_USER_DEFAULT
) (
  // Clock and reset
  input  wire                clk,
  input  wire                rst,
  // Straps
  input  wire                rom_boot_select,
  input  wire [2:0]          core_speed_select,
  // Start-up sequencing status
  input  wire                scan_found,
  input  wire                refresh_enable,
  output reg                 config_read_reg,
  output reg                 refresh_cycle_reg,
  output reg                 scan_active_reg,
  output reg                 boot_done_reg,
  output reg                 rom_boot_reg,
  output reg                 low_priority_reg,
  output reg  [AW-1:0]       start_pc_reg,
  output reg  [AW-1:0]       workspace_reg,
  // Incoming link bytes
  input  wire [NLINK-1:0]    rx_valid,
  input  wire [NLINK*8-1:0]  rx_data,
  output reg  [NLINK-1:0]    rx_ack_reg,
  // Outgoing link bytes
  output reg  [NLINK-1:0]    tx_valid_reg,
  output reg  [7:0]          tx_data_reg,
  input  wire [NLINK-1:0]    tx_ready,
  // Memory port
  output reg                 mem_req_reg,
  output reg                 mem_we_reg,
  output reg  [AW-1:0]       mem_addr_reg,
  output reg  [31:0]         mem_wdata_reg,
  input  wire                mem_done,
  input  wire [31:0]         mem_rdata
);
  localparam S_DELAY = 10'h001;
  localparam S_SCAN  = 10'h002;
  localparam S_CFG   = 10'h004;
  localparam S_CDLY  = 10'h008;
  localparam S_REFR  = 10'h010;
  localparam S_CTRL  = 10'h020;
  localparam S_OPER  = 10'h040;
  localparam S_MEM   = 10'h080;
  localparam S_SEND  = 10'h100;
  localparam S_RUN   = 10'h200;
  localparam integer DELAY_N  = `RESET_DELAY_REFS * `CYC_PER_REF;
  localparam integer SCAN_N   = `SCAN_REFS * `CYC_PER_REF;
  localparam integer CFG_N    = `CYC_PER_REF;
  localparam [15:0] DELAY_CYC = DELAY_N[15:0];
  localparam [15:0] SCAN_CYC  = SCAN_N[15:0];
  localparam [15:0] CFG_CYC   = CFG_N[15:0];

  reg [9:0]        state_reg;
  reg [15:0]       timer_reg;
  reg [7:0]        phase_cnt_reg;
  reg              boot_sel_reg;
  reg [1:0]        link_reg;
  reg [7:0]        ctrl_reg;
  reg [3:0]        nbytes_reg;
  reg [31:0]       addr_w_reg;
  reg [31:0]       data_w_reg;
  reg [AW-1:0]     load_addr_reg;
  reg [7:0]        remain_reg;
  reg              loading_reg;
  reg [1:0]        tx_idx_reg;
  reg              tx_busy_reg;
  reg [7:0]        sel_byte;
  reg              sel_valid;
  reg              any_valid;
  reg [1:0]        any_link;
  integer          i;
  wire             buf_in_ready;
  wire             buf_out_valid;
  wire [7:0]       buf_out_data;
  wire             buf_pop;
  wire             take;

  // Boot link byte selection
  always @* begin
    sel_byte  = 8'h00;
    sel_valid = 1'b0;
    any_valid = 1'b0;
    any_link  = 2'h0;
    for (i = NLINK-1; i >= 0; i = i - 1) begin
      if (rx_valid[i]) begin
        any_valid = 1'b1;
        any_link  = i[1:0];
      end
    end
    sel_byte  = rx_data[link_reg*8 +: 8];
    sel_valid = rx_valid[link_reg] & ~rx_ack_reg[link_reg];
  end

  // Reply word staged through the two-entry buffer
  assign take    = (state_reg == S_SEND) && tx_busy_reg == 1'b0 && buf_in_ready;
  assign buf_pop = buf_out_valid && (tx_valid_reg == {NLINK{1'b0}});

  pair_buffer #(.WIDTH(8)) reply_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (take),
    .in_ready  (buf_in_ready),
    .in_data   (data_w_reg[tx_idx_reg*8 +: 8]),
    .out_valid (buf_out_valid),
    .out_ready (buf_pop),
    .out_data  (buf_out_data)
  );

  always @(posedge clk) begin
    if (rst) begin
      state_reg         <= S_DELAY;
      timer_reg         <= 16'h0000;
      phase_cnt_reg     <= 8'h00;
      boot_sel_reg      <= 1'b0;
      link_reg          <= 2'h0;
      ctrl_reg          <= 8'h00;
      nbytes_reg        <= 4'h0;
      addr_w_reg        <= 32'h00000000;
      data_w_reg        <= 32'h00000000;
      load_addr_reg     <= {AW{1'b0}};
      remain_reg        <= 8'h00;
      loading_reg       <= 1'b0;
      tx_idx_reg        <= 2'h0;
      tx_busy_reg       <= 1'b0;
      config_read_reg   <= 1'b0;
      refresh_cycle_reg <= 1'b0;
      scan_active_reg   <= 1'b0;
      boot_done_reg     <= 1'b0;
      rom_boot_reg      <= 1'b0;
      low_priority_reg  <= 1'b0;
      start_pc_reg      <= {AW{1'b0}};
      workspace_reg     <= {AW{1'b0}};
      rx_ack_reg        <= {NLINK{1'b0}};
      tx_valid_reg      <= {NLINK{1'b0}};
      tx_data_reg       <= 8'h00;
      mem_req_reg       <= 1'b0;
      mem_we_reg        <= 1'b0;
      mem_addr_reg      <= {AW{1'b0}};
      mem_wdata_reg     <= 32'h00000000;
    end else begin
      rx_ack_reg <= {NLINK{1'b0}};
      // Byte transmit on the boot link
      if (buf_pop) begin
        tx_valid_reg[link_reg] <= 1'b1;
        tx_data_reg            <= buf_out_data;
      end else if (tx_valid_reg[link_reg] && tx_ready[link_reg]) begin
        tx_valid_reg <= {NLINK{1'b0}};
      end
      case (state_reg)
        S_DELAY: begin
          if (timer_reg == 16'h0000)
            boot_sel_reg <= rom_boot_select;
          if (timer_reg == DELAY_CYC - 16'h0001) begin
            timer_reg       <= 16'h0000;
            scan_active_reg <= 1'b1;
            state_reg       <= S_SCAN;
          end else begin
            timer_reg <= timer_reg + 16'h0001;
          end
        end
        S_SCAN: begin
          if (timer_reg == SCAN_CYC - 16'h0001) begin
            timer_reg       <= 16'h0000;
            scan_active_reg <= 1'b0;
            phase_cnt_reg   <= 8'h00;
            state_reg       <= S_CFG;
          end else begin
            timer_reg <= timer_reg + 16'h0001;
          end
        end
        S_CFG: begin
          // Reads run regardless of scan_found
          config_read_reg <= (timer_reg == 16'h0000);
          if (timer_reg == CFG_CYC - 16'h0001) begin
            timer_reg <= 16'h0000;
            if (phase_cnt_reg == `CONFIG_READS - 1) begin
              phase_cnt_reg <= 8'h00;
              state_reg     <= S_CDLY;
            end else begin
              phase_cnt_reg <= phase_cnt_reg + 8'h01;
            end
          end else begin
            timer_reg <= timer_reg + 16'h0001;
          end
        end
        S_CDLY: begin
          config_read_reg <= 1'b0;
          if (timer_reg == CFG_DELAY - 1) begin
            timer_reg <= 16'h0000;
            state_reg <= S_REFR;
          end else begin
            timer_reg <= timer_reg + 16'h0001;
          end
        end
        S_REFR: begin
          refresh_cycle_reg <= refresh_enable && (timer_reg == 16'h0000);
          if (timer_reg == CFG_CYC - 16'h0001) begin
            timer_reg <= 16'h0000;
            if (phase_cnt_reg == `REFRESH_COUNT - 1) begin
              phase_cnt_reg    <= 8'h00;
              low_priority_reg <= 1'b1;
              if (boot_sel_reg) begin
                rom_boot_reg  <= 1'b1;
                start_pc_reg  <= `ROM_BOOT_ADDR;
                workspace_reg <= START_ADDR;
                boot_done_reg <= 1'b1;
                state_reg     <= S_RUN;
              end else begin
                state_reg <= S_CTRL;
              end
            end else begin
              phase_cnt_reg <= phase_cnt_reg + 8'h01;
            end
          end else begin
            timer_reg <= timer_reg + 16'h0001;
          end
        end
        S_CTRL: begin
          refresh_cycle_reg <= 1'b0;
          if (any_valid) begin
            link_reg              <= any_link;
            ctrl_reg              <= rx_data[any_link*8 +: 8];
            rx_ack_reg[any_link]  <= 1'b1;
            nbytes_reg            <= 4'h0;
            load_addr_reg         <= START_ADDR;
            remain_reg            <= rx_data[any_link*8 +: 8];
            loading_reg           <= (rx_data[any_link*8 +: 8] > `CTRL_PEEK);
            state_reg             <= S_OPER;
          end
        end
        S_OPER: begin
          // Other links stay unacknowledged
          if (sel_valid) begin
            rx_ack_reg[link_reg] <= 1'b1;
            if (loading_reg) begin
              mem_req_reg   <= 1'b1;
              mem_we_reg    <= 1'b1;
              mem_addr_reg  <= load_addr_reg;
              mem_wdata_reg <= {24'h000000, sel_byte};
              load_addr_reg <= load_addr_reg + {{(AW-1){1'b0}}, 1'b1};
              remain_reg    <= remain_reg - 8'h01;
              state_reg     <= S_MEM;
            end else begin
              if (nbytes_reg < 4'h4)
                addr_w_reg <= {sel_byte, addr_w_reg[31:8]};
              else
                data_w_reg <= {sel_byte, data_w_reg[31:8]};
              nbytes_reg <= nbytes_reg + 4'h1;
              if ((ctrl_reg == `CTRL_PEEK && nbytes_reg == 4'h3) ||
                  (ctrl_reg == `CTRL_POKE && nbytes_reg == 4'h7)) begin
                mem_req_reg   <= 1'b1;
                mem_we_reg    <= (ctrl_reg == `CTRL_POKE);
                mem_addr_reg  <= (ctrl_reg == `CTRL_POKE) ? addr_w_reg[AW-1:0] :
                                 {sel_byte, addr_w_reg[31:8]};
                mem_wdata_reg <= {sel_byte, data_w_reg[31:8]};
                state_reg     <= S_MEM;
              end
            end
          end
        end
        S_MEM: begin
          if (mem_done) begin
            mem_req_reg <= 1'b0;
            mem_we_reg  <= 1'b0;
            if (loading_reg) begin
              if (remain_reg == 8'h00) begin
                start_pc_reg  <= START_ADDR;
                workspace_reg <= load_addr_reg;
                boot_done_reg <= 1'b1;
                state_reg     <= S_RUN;
              end else begin
                state_reg <= S_OPER;
              end
            end else if (ctrl_reg == `CTRL_PEEK) begin
              data_w_reg  <= mem_rdata;
              tx_idx_reg  <= 2'h0;
              tx_busy_reg <= 1'b0;
              state_reg   <= S_SEND;
            end else begin
              state_reg <= S_CTRL;
            end
          end
        end
        S_SEND: begin
          if (take) begin
            tx_idx_reg <= tx_idx_reg + 2'h1;
            if (tx_idx_reg == 2'h3)
              tx_busy_reg <= 1'b1;
          end
          if (tx_busy_reg && !buf_out_valid && tx_valid_reg == {NLINK{1'b0}})
            state_reg <= S_CTRL;
        end
        S_RUN: begin
          state_reg <= S_RUN;
        end
        default: begin
          state_reg <= S_DELAY;
        end
      endcase
    end
  end
endmodule

// ### tb/boot_loader_assertions.sv
`timescale 1ns/1ps
module boot_loader_assertions #(
  parameter NLINK      = 4,
  parameter AW         = 32,
  parameter START_ADDR = 32'h80000070
) (
  // Clock and reset
  input logic             clk,
  input logic             rst,
  // Sequencing
  input logic             refresh_enable,
  input logic             config_read_reg,
  input logic             refresh_cycle_reg,
  input logic             scan_active_reg,
  input logic             boot_done_reg,
  input logic             rom_boot_reg,
  input logic             low_priority_reg,
  input logic [AW-1:0]    start_pc_reg,
  input logic [AW-1:0]    workspace_reg,
  // Links and memory
  input logic [NLINK-1:0] rx_ack_reg,
  input logic [NLINK-1:0] tx_valid_reg,
  input logic [7:0]       tx_data_reg,
  input logic [NLINK-1:0] tx_ready,
  input logic             mem_req_reg,
  input logic [AW-1:0]    mem_addr_reg,
  input logic             mem_done
);
  logic [11:0] n_scan_reg;
  logic [7:0]  n_cfg_reg;
  logic [7:0]  n_ref_reg;
  // Phase tallies
  always @(posedge clk) begin
    if (rst) begin
      n_scan_reg <= 12'h000;
      n_cfg_reg <= 8'h00;
      n_ref_reg <= 8'h00;
    end else begin
      n_scan_reg <= n_scan_reg + {11'h000, scan_active_reg};
      n_cfg_reg <= n_cfg_reg + {7'h00, config_read_reg};
      n_ref_reg <= n_ref_reg + {7'h00, refresh_cycle_reg};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_out_low; $fell(rst) |-> tx_valid_reg == 0 && rx_ack_reg == 0 && !mem_req_reg; endproperty
  property p_scan_len; $fell(scan_active_reg) |-> n_scan_reg == 12'h240; endproperty
  property p_cfg_after; config_read_reg |-> n_scan_reg == 12'h240 && !scan_active_reg; endproperty
  property p_cfg_cnt; $rose(refresh_cycle_reg) |-> n_cfg_reg == 8'h24; endproperty
  property p_ref_cnt; boot_done_reg && refresh_enable |-> n_ref_reg == 8'h08; endproperty
  property p_ref_off; !refresh_enable |-> !refresh_cycle_reg; endproperty
  property p_ack_late; rx_ack_reg != 0 |-> n_cfg_reg == 8'h24 && (n_ref_reg == 8'h08 || !refresh_enable); endproperty
  property p_rom; boot_done_reg && rom_boot_reg |->
    start_pc_reg == 32'h07FFFFFE && workspace_reg == START_ADDR && low_priority_reg; endproperty
  property p_link; boot_done_reg && !rom_boot_reg |-> start_pc_reg == START_ADDR && low_priority_reg; endproperty
  property p_sticky; !$fell(rom_boot_reg) && !$fell(boot_done_reg); endproperty
  property p_quiet; boot_done_reg && $past(boot_done_reg) |-> rx_ack_reg == 0; endproperty
  property p_mem_hold; mem_req_reg && !mem_done |=> mem_req_reg && $stable(mem_addr_reg); endproperty
  property p_tx_hold; (tx_valid_reg & ~tx_ready) != 0 |=> $stable(tx_valid_reg) && $stable(tx_data_reg); endproperty
  a_out_low: assert property (p_out_low) else $error("link output active at reset end");
  a_scan_len: assert property (p_scan_len) else $error("scan length wrong");
  a_cfg_after: assert property (p_cfg_after) else $error("config read before scan end");
  a_cfg_cnt: assert property (p_cfg_cnt) else $error("config read count wrong");
  a_ref_cnt: assert property (p_ref_cnt) else $error("refresh count wrong");
  a_ref_off: assert property (p_ref_off) else $error("refresh while disabled");
  a_ack_late: assert property (p_ack_late) else $error("link byte taken too early");
  a_rom: assert property (p_rom) else $error("rom boot state wrong");
  a_link: assert property (p_link) else $error("link boot state wrong");
  a_sticky: assert property (p_sticky) else $error("boot state changed");
  a_quiet: assert property (p_quiet) else $error("ack after boot");
  a_mem_hold: assert property (p_mem_hold) else $error("memory request dropped");
  a_tx_hold: assert property (p_tx_hold) else $error("reply byte changed early");
  c_rom: cover property ($rose(boot_done_reg) && rom_boot_reg);
  c_link: cover property ($rose(boot_done_reg) && !rom_boot_reg);
  c_stall: cover property ((tx_valid_reg & ~tx_ready) != 0);
endmodule

bind reset_link_boot_loader boot_loader_assertions #(.NLINK(NLINK), .AW(AW), .START_ADDR(START_ADDR)) chk_u (
  .clk(clk), .rst(rst), .refresh_enable(refresh_enable), .config_read_reg(config_read_reg),
  .refresh_cycle_reg(refresh_cycle_reg), .scan_active_reg(scan_active_reg), .boot_done_reg(boot_done_reg),
  .rom_boot_reg(rom_boot_reg), .low_priority_reg(low_priority_reg), .start_pc_reg(start_pc_reg),
  .workspace_reg(workspace_reg), .rx_ack_reg(rx_ack_reg), .tx_valid_reg(tx_valid_reg),
  .tx_data_reg(tx_data_reg), .tx_ready(tx_ready), .mem_req_reg(mem_req_reg), .mem_addr_reg(mem_addr_reg),
  .mem_done(mem_done));

// ### tb/link_host_model.sv
`timescale 1ns/1ps
module link_host_model (
  // Clock
  input  logic        clk,
  // Bytes toward the loader
  output logic [3:0]  rx_valid,
  output logic [31:0] rx_data,
  input  logic [3:0]  rx_ack,
  // Bytes from the loader
  input  logic [3:0]  tx_valid,
  input  logic [7:0]  tx_data,
  output logic [3:0]  tx_ready
);
  logic [7:0] got_q[$];
  logic [3:0] lane_q[$];
  logic       slow = 1'b0;
  logic [1:0] ph = 2'h0;
  // Inputs low from the start
  initial begin
    rx_valid = 4'h0;
    rx_data = 32'h0;
  end
  // Sink stalls two cycles in three when slow
  always @(negedge clk) begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    tx_ready <= (!slow || ph == 2'h0) ? 4'hF : 4'h0;
  end
  always @(posedge clk) begin
    if ((tx_valid & tx_ready) != 4'h0) begin
      got_q.push_back(tx_data);
      lane_q.push_back(tx_valid);
    end
  end
  task put(input int l, input logic [7:0] b);
    @(negedge clk);
    rx_data[8*l +: 8] = b;
    rx_valid[l] = 1'b1;
  endtask
  // Hold until acknowledged, then release and scramble the lane
  task take(input int l, input int lim, output bit ok);
    ok = 1'b0;
    repeat (lim) begin
      @(negedge clk);
      if (rx_ack[l] === 1'b1) begin
        ok = 1'b1;
        break;
      end
    end
    if (ok) begin
      rx_valid[l] = 1'b0;
      rx_data[8*l +: 8] = ~rx_data[8*l +: 8];
    end
  endtask
  task send(input int l, input logic [7:0] b, output bit ok);
    put(l, b);
    take(l, 8, ok);
  endtask
endmodule

// ### tb/reset_link_boot_loader_tb_top.sv
`timescale 1ns/1ps
module reset_link_boot_loader_tb_top;
  localparam logic [31:0] START = 32'h80000070;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rom_boot_select = 1'b0;
  logic refresh_enable = 1'b1;
  logic mem_done = 1'b0;
  logic [31:0] mem_rdata = 32'h0;
  logic [31:0] mem [logic [31:0]];
  wire config_read_reg, refresh_cycle_reg, scan_active_reg, boot_done_reg, rom_boot_reg, low_priority_reg;
  wire mem_req_reg, mem_we_reg;
  wire [31:0] start_pc_reg, workspace_reg, mem_addr_reg, mem_wdata_reg, rx_data;
  wire [3:0] rx_ack_reg, tx_valid_reg, rx_valid, tx_ready;
  wire [7:0] tx_data_reg;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int mwait = 0;
  bit ok;
  always #25 clk = ~clk;
  reset_link_boot_loader #(.CFG_DELAY(4)) dut_u (.clk(clk), .rst(rst), .rom_boot_select(rom_boot_select),
    .core_speed_select(3'h0), .scan_found(1'b0), .refresh_enable(refresh_enable),
    .config_read_reg(config_read_reg), .refresh_cycle_reg(refresh_cycle_reg), .scan_active_reg(scan_active_reg),
    .boot_done_reg(boot_done_reg), .rom_boot_reg(rom_boot_reg), .low_priority_reg(low_priority_reg),
    .start_pc_reg(start_pc_reg), .workspace_reg(workspace_reg), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ack_reg(rx_ack_reg), .tx_valid_reg(tx_valid_reg), .tx_data_reg(tx_data_reg), .tx_ready(tx_ready),
    .mem_req_reg(mem_req_reg), .mem_we_reg(mem_we_reg), .mem_addr_reg(mem_addr_reg),
    .mem_wdata_reg(mem_wdata_reg), .mem_done(mem_done), .mem_rdata(mem_rdata));
  link_host_model host_u (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ack(rx_ack_reg),
    .tx_valid(tx_valid_reg), .tx_data(tx_data_reg), .tx_ready(tx_ready));
  // Memory answers on the third cycle of a request
  always @(negedge clk) begin
    mem_done <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req_reg && !mem_done) begin
      mwait <= mwait + 1;
      if (mwait == 2) begin
        mwait <= 0;
        mem_done <= 1'b1;
        if (mem_we_reg)
          mem[mem_addr_reg] = mem_wdata_reg;
        else
          mem_rdata <= mem.exists(mem_addr_reg) ? mem[mem_addr_reg] : 32'h0;
      end
    end
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task run_startup(input logic rom, input logic ren);
    int n_scan, n_cfg, n_ref;
    n_scan = 0;
    n_cfg = 0;
    n_ref = 0;
    rst = 1'b1;
    rom_boot_select = rom;
    refresh_enable = ren;
    repeat (12) @(negedge clk);
    chk("tx_valid_reg in reset", 32'h0, {28'h0, tx_valid_reg});
    rst = 1'b0;
    repeat (1360) begin
      @(negedge clk);
      n_scan += scan_active_reg;
      n_cfg += config_read_reg;
      n_ref += refresh_cycle_reg;
    end
    chk("scan cycles", 32'h240, n_scan);
    chk("config reads", 32'h24, n_cfg);
    chk("refresh cycles", ren ? 32'h8 : 32'h0, n_ref);
    chk("boot_done_reg", {31'h0, rom}, {31'h0, boot_done_reg});
  endtask
  task send_word(input int l, input logic [31:0] w);
    for (int i = 0; i < 4; i++) begin
      host_u.send(l, w[8*i +: 8], ok);
      chk("operand ack", 32'h1, {31'h0, ok});
    end
  endtask
  task t_rom_boot;
    run_startup(1'b1, 1'b0);
    chk("rom_boot_reg", 32'h1, {31'h0, rom_boot_reg});
    chk("start_pc_reg", 32'h07FFFFFE, start_pc_reg);
    chk("workspace_reg", START, workspace_reg);
    chk("low_priority_reg", 32'h1, {31'h0, low_priority_reg});
  endtask
  task t_peek(input int l, input logic [31:0] a);
    host_u.got_q.delete();
    host_u.lane_q.delete();
    host_u.send(l, 8'h01, ok);
    chk("peek control ack", 32'h1, {31'h0, ok});
    send_word(l, a);
    for (int k = 0; k < 300 && host_u.got_q.size() < 4; k++) @(negedge clk);
    chk("reply bytes", 32'h4, host_u.got_q.size());
    for (int i = 0; i < 4 && i < host_u.got_q.size(); i++) begin
      chk("reply byte", {24'h0, mem[a][8*i +: 8]}, {24'h0, host_u.got_q[i]});
      chk("reply lane", {28'h0, 4'h1 << l}, {28'h0, host_u.lane_q[i]});
    end
  endtask
  task t_poke_peek;
    mem[32'h00000200] = 32'h12345678;
    host_u.send(2, 8'h00, ok);
    chk("poke control ack", 32'h1, {31'h0, ok});
    send_word(2, 32'h00000104);
    send_word(2, 32'hA5C31E7B);
    for (int k = 0; k < 40 && !mem.exists(32'h104); k++) @(negedge clk);
    chk("poked word", 32'hA5C31E7B, mem.exists(32'h104) ? mem[32'h104] : 32'hX);
    host_u.slow = 1'b1;
    t_peek(1, 32'h00000200);
    host_u.slow = 1'b0;
    t_peek(3, 32'h00000104);
  endtask
  task t_load;
    host_u.send(0, 8'h03, ok);
    chk("load control ack", 32'h1, {31'h0, ok});
    host_u.put(3, 8'h5A);
    for (int i = 0; i < 3; i++) begin
      host_u.send(0, 8'hC0 + i[7:0], ok);
      chk("code byte ack", 32'h1, {31'h0, ok});
    end
    for (int k = 0; k < 40 && boot_done_reg !== 1'b1; k++) @(negedge clk);
    host_u.take(3, 30, ok);
    chk("other link ack", 32'h0, {31'h0, ok});
    for (int i = 0; i < 3; i++)
      chk("code byte", 32'hC0 + i, mem.exists(START + i) ? {24'h0, mem[START + i][7:0]} : 32'hX);
    chk("boot_done_reg", 32'h1, {31'h0, boot_done_reg});
    chk("start_pc_reg", START, start_pc_reg);
    chk("workspace_reg", START + 3, workspace_reg);
    chk("low_priority_reg", 32'h1, {31'h0, low_priority_reg});
    host_u.put(0, 8'h77);
    host_u.take(0, 20, ok);
    chk("boot link ack after load", 32'h0, {31'h0, ok});
    rom_boot_select = 1'b1;
    @(negedge clk);
    chk("rom_boot_reg", 32'h0, {31'h0, rom_boot_reg});
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 9000) begin
      fails++;
      $display("run exceeded cycle ceiling");
      print_verdict;
    end
  end
  initial begin
    t_rom_boot;
    run_startup(1'b0, 1'b1);
    t_poke_peek;
    t_load;
    print_verdict;
  end
endmodule
